// file: rtl/dmc_core.sv
`timescale 1ns/1ns
module dmc_core
  import dmc_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              clk_en,
  input  wire logic [3:0]        reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [15:0]       reg_rdata,
  input  wire logic              loop_push,
  input  wire logic              loop_pop,
  output logic                   loop_exit_req,
  output logic                   acc_a_clamp_en,
  output logic                   acc_b_clamp_en,
  output logic                   data_write_clamp_en,
  output logic                   clamp_width_sel,
  output logic                   prog_window_en,
  output logic      [3:0]        prio_level,
  output logic                   prod_valid,
  output logic      [39:0]       prod_ext
);

  // control state
  logic [15:0]       ctrl_r;
  logic [2:0]        depth_r;
  logic [2:0]        prio_low_r;
  logic              exit_r;
  logic [DATA_W-1:0] opa_r;
  logic [DATA_W-1:0] opb_r;
  logic [4:0]        cmd_r;
  logic              go_r;
  logic [39:0]       prod_r;
  logic              pv_r;
  logic [15:0]       rdata_r;

  // address decode
  wire wr_ctrl = reg_wr && (reg_addr == CORE_CONTROL_ADDR);
  wire wr_opa  = reg_wr && (reg_addr == MULT_OPA_ADDR);
  wire wr_opb  = reg_wr && (reg_addr == MULT_OPB_ADDR);
  wire wr_cmd  = reg_wr && (reg_addr == MULT_CMD_ADDR);
  wire wr_prio = reg_wr && (reg_addr == PRIO_LOW_ADDR);

  // control register: only writable bits stored, reserved and status bits masked out
  wire [15:0] ctrl_nxt = (reg_wdata & CORE_CONTROL_WMASK);

  // priority level: msb is set only when the joined level exceeds 7
  wire [3:0] prio_join = {ctrl_r[PRIO_LEVEL_MSB_BIT], prio_low_r};

  // operand extension to 17 bits; dsp ops follow the control unsigned select,
  // integer ops take per-operand signedness for mixed-sign support
  wire dsp_op   = cmd_r[CMD_DSP_BIT];
  wire us_sel   = ctrl_r[UNSIGNED_MULT_SEL_BIT];
  wire a_signed = dsp_op ? !us_sel : cmd_r[CMD_A_SIGN_BIT];
  wire b_signed = dsp_op ? !us_sel : cmd_r[CMD_B_SIGN_BIT];
  wire byte_op  = cmd_r[CMD_BYTE_BIT] && !dsp_op;
  wire [7:0] opa_b = opa_r[7:0];
  wire [7:0] opb_b = opb_r[7:0];
  wire [DATA_W-1:0] opa_w = byte_op ? {{8{a_signed & opa_b[7]}}, opa_b} : opa_r;
  wire [DATA_W-1:0] opb_w = byte_op ? {{8{b_signed & opb_b[7]}}, opb_b} : opb_r;
  wire [DATA_W:0] ext_a = {a_signed & opa_w[DATA_W-1], opa_w};
  wire [DATA_W:0] ext_b = {b_signed & opb_w[DATA_W-1], opb_w};

  // 17x17 signed product; low 32 bits hold every legal result
  wire signed [33:0] raw_prod = $signed(ext_a) * $signed(ext_b);
  // fractional scaling drops the duplicate sign: shift left by one into 1.31
  wire [31:0] frac_prod = {raw_prod[30:0], 1'b0};
  wire [31:0] int_prod  = raw_prod[31:0];
  wire [31:0] scaled    = (cmd_r[CMD_FRAC_BIT] && dsp_op) ? frac_prod : int_prod;
  // byte ops keep 16 bits, word ops keep 32
  wire [31:0] sized     = byte_op ? {16'h0000, int_prod[15:0]} : scaled;
  // sign extension to the 40-bit accumulator width; byte ops and unsigned word ops zero-fill
  wire prod_sign = (a_signed | b_signed) ? sized[31] : 1'b0;
  wire [39:0] prod_nxt = byte_op ? {24'h000000, sized[15:0]} : {{8{prod_sign}}, sized};

  // read mux; early exit bit and reserved bits read zero
  wire [15:0] ctrl_rd = {3'h0, ctrl_r[UNSIGNED_MULT_SEL_BIT], 1'b0, depth_r,
                         ctrl_r[7:3], ctrl_r[PROG_WINDOW_EN_BIT], 2'h0};
  logic [15:0] rdata_nxt;
  always_comb begin
    unique case (reg_addr)
      CORE_CONTROL_ADDR: rdata_nxt = ctrl_rd;
      MULT_OPA_ADDR:     rdata_nxt = opa_r;
      MULT_OPB_ADDR:     rdata_nxt = opb_r;
      MULT_CMD_ADDR:     rdata_nxt = {11'h000, cmd_r};
      PROD_LO_ADDR:      rdata_nxt = prod_r[15:0];
      PROD_HI_ADDR:      rdata_nxt = prod_r[31:16];
      PROD_EXT_ADDR:     rdata_nxt = {8'h00, prod_r[39:32]};
      PRIO_LOW_ADDR:     rdata_nxt = {13'h0000, prio_low_r};
      default:           rdata_nxt = 16'h0000;
    endcase
  end

  // loop depth tracking saturates at seven and zero
  wire [2:0] depth_nxt = (loop_push && !loop_pop && depth_r != 3'(MAX_LOOP_DEPTH)) ? depth_r + 3'h1 :
                         (loop_pop && !loop_push && depth_r != 3'h0) ? depth_r - 3'h1 : depth_r;

  // register file and control
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_r     <= CORE_CONTROL_RESET;
      prio_low_r <= 3'h0;
      depth_r    <= 3'h0;
      exit_r     <= 1'b0;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        ctrl_r <= ctrl_nxt;
      end
      if (wr_prio) begin
        prio_low_r <= reg_wdata[2:0];
      end
      depth_r <= depth_nxt;
      // a one requests exit at nonzero depth; a zero does nothing; the request clears when the loop pops, unless a one is written in that same cycle
      if (wr_ctrl && reg_wdata[LOOP_EARLY_EXIT_BIT] && depth_r != 3'h0) begin
        exit_r <= 1'b1;
      end else if (loop_pop || depth_r == 3'h0) begin
        exit_r <= 1'b0;
      end
    end
  end

  // multiplier operands and product; two cycles from command write to result
  always_ff @(posedge clk) begin
    if (!rstn) begin
      opa_r  <= '0;
      opb_r  <= '0;
      cmd_r  <= 5'h00;
      go_r   <= 1'b0;
      prod_r <= 40'h0000000000;
      pv_r   <= 1'b0;
    end else if (clk_en) begin
      if (wr_opa) opa_r <= reg_wdata;
      if (wr_opb) opb_r <= reg_wdata;
      if (wr_cmd) cmd_r <= reg_wdata[4:0];
      go_r <= wr_cmd;
      pv_r <= go_r;
      if (go_r) prod_r <= prod_nxt;
    end
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_r <= 16'h0000;
    end else if (clk_en) begin
      rdata_r <= reg_rd ? rdata_nxt : 16'h0000;
    end
  end

  // clamp controls go straight from flops to the accumulator clamp stage
  assign acc_a_clamp_en      = ctrl_r[ACC_A_CLAMP_EN_BIT];
  assign acc_b_clamp_en      = ctrl_r[ACC_B_CLAMP_EN_BIT];
  assign data_write_clamp_en = ctrl_r[DATA_WRITE_CLAMP_EN_BIT];
  assign clamp_width_sel     = ctrl_r[CLAMP_WIDTH_SEL_BIT];
  assign prog_window_en      = ctrl_r[PROG_WINDOW_EN_BIT];
  assign prio_level          = prio_join;
  assign loop_exit_req       = exit_r;
  assign prod_valid          = pv_r;
  assign prod_ext            = prod_r;
  assign reg_rdata           = rdata_r;

  // assertions
  // multiply steps: the command is taken, then the go cycle forms the product
  sequence s_cmd_taken;
    wr_cmd && clk_en;
  endsequence
  sequence s_go_cycle;
    go_r && clk_en;
  endsequence
  // go cycles sorted by the kind of product they form; fractional signed
  // corner cases are left to the 1.31 check, since -1.0 squared wraps there
  sequence s_dsp_unsigned_go;
    go_r && clk_en && dsp_op && us_sel && !cmd_r[CMD_FRAC_BIT];
  endsequence
  sequence s_signed_word_go;
    go_r && clk_en && a_signed && b_signed && !byte_op && !(dsp_op && cmd_r[CMD_FRAC_BIT]);
  endsequence
  sequence s_frac_go;
    go_r && clk_en && dsp_op && !us_sel && cmd_r[CMD_FRAC_BIT];
  endsequence
  sequence s_byte_go;
    go_r && clk_en && byte_op;
  endsequence

  // control register writes and read-back; a write lands one cycle after its strobe
  a_exit_reads_zero: assert property (@(posedge clk) disable iff (!rstn)
    reg_rd && reg_addr == CORE_CONTROL_ADDR && clk_en |=> reg_rdata[LOOP_EARLY_EXIT_BIT] == 1'b0)
    else $error("early exit bit read back as one");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!rstn)
    reg_rd && clk_en && reg_addr == CORE_CONTROL_ADDR |=> reg_rdata[15:13] == 3'h0)
    else $error("reserved bits not zero");
  a_reserved_store: assert property (@(posedge clk) disable iff (!rstn)
    wr_ctrl && clk_en |=> (ctrl_r & ~CORE_CONTROL_WMASK) == 16'h0000)
    else $error("reserved or status bit stored from a write");
  a_us_write: assert property (@(posedge clk) disable iff (!rstn)
    wr_ctrl && clk_en |=> us_sel == $past(reg_wdata[UNSIGNED_MULT_SEL_BIT]))
    else $error("unsigned select not taken");
  a_clamp_a_write: assert property (@(posedge clk) disable iff (!rstn)
    wr_ctrl && clk_en |=> acc_a_clamp_en == $past(reg_wdata[ACC_A_CLAMP_EN_BIT]))
    else $error("acc a clamp enable not taken");
  a_clamp_b_write: assert property (@(posedge clk) disable iff (!rstn)
    wr_ctrl && clk_en |=> acc_b_clamp_en == $past(reg_wdata[ACC_B_CLAMP_EN_BIT]))
    else $error("acc b clamp enable not taken");
  a_dw_clamp_write: assert property (@(posedge clk) disable iff (!rstn)
    wr_ctrl && clk_en |=> data_write_clamp_en == $past(reg_wdata[DATA_WRITE_CLAMP_EN_BIT]))
    else $error("data write clamp enable not taken");
  a_width_write: assert property (@(posedge clk) disable iff (!rstn)
    wr_ctrl && clk_en |=> clamp_width_sel == $past(reg_wdata[CLAMP_WIDTH_SEL_BIT]))
    else $error("clamp width select not taken");
  a_prio_msb: assert property (@(posedge clk) disable iff (!rstn)
    prio_level[3] == (prio_level > PRIO_MSB_THRESHOLD))
    else $error("priority msb inconsistent");
  a_prio_low_write: assert property (@(posedge clk) disable iff (!rstn)
    wr_prio && clk_en |=> prio_level[2:0] == $past(reg_wdata[2:0]))
    else $error("low priority bits not taken");

  // multiplier: timing, holding, the value of unsigned dsp, signed word and fractional products, and the width of byte products
  // the product only moves in a go cycle, so software may read it at leisure
  a_prod_timing: assert property (@(posedge clk) disable iff (!rstn)
    wr_cmd && clk_en ##1 clk_en |=> prod_valid)
    else $error("product not valid two cycles after command");
  a_valid_ends: assert property (@(posedge clk) disable iff (!rstn)
    s_cmd_taken ##1 s_go_cycle ##1 !go_r && clk_en |=> !prod_valid)
    else $error("product valid longer than one cycle");
  a_valid_pulse: assert property (@(posedge clk) disable iff (!rstn)
    !go_r && clk_en |=> !prod_valid)
    else $error("product valid without a command");
  a_prod_holds: assert property (@(posedge clk) disable iff (!rstn)
    !go_r && clk_en |=> $stable(prod_ext))
    else $error("product changed without a command");
  a_prod_sext: assert property (@(posedge clk) disable iff (!rstn)
    prod_valid && !$past(byte_op) && $past(prod_sign) |-> prod_ext[39:32] == 8'hFF)
    else $error("product not sign-extended");
  a_unsigned_product: assert property (@(posedge clk) disable iff (!rstn)
    s_dsp_unsigned_go |=> prod_ext == {8'h00, 32'($past(opa_r)) * 32'($past(opb_r))})
    else $error("unsigned dsp product wrong");
  a_signed_product: assert property (@(posedge clk) disable iff (!rstn)
    s_signed_word_go |=> prod_ext == 40'($signed($past(opa_r)) * $signed($past(opb_r))))
    else $error("signed word product wrong");
  a_frac_product: assert property (@(posedge clk) disable iff (!rstn)
    s_frac_go |=> prod_ext[31:0] == 32'($signed($past(opa_r)) * $signed($past(opb_r)) * 2)
      && prod_ext[39:32] == {8{prod_ext[31]}})
    else $error("fractional product not in 1.31 form");
  a_byte_result: assert property (@(posedge clk) disable iff (!rstn)
    s_byte_go |=> prod_ext[39:16] == 24'h000000)
    else $error("byte product wider than 16 bits");
  a_prod_lo_read: assert property (@(posedge clk) disable iff (!rstn)
    reg_rd && clk_en && reg_addr == PROD_LO_ADDR |=> reg_rdata == $past(prod_r[15:0]))
    else $error("product low word read wrong");
  a_prod_ext_read: assert property (@(posedge clk) disable iff (!rstn)
    reg_rd && clk_en && reg_addr == PROD_EXT_ADDR |=> reg_rdata == {8'h00, $past(prod_r[39:32])})
    else $error("product extension read wrong");

  // loop nesting, early exit and the clock enable
  a_depth_max: assert property (@(posedge clk) disable iff (!rstn)
    depth_r == 3'(MAX_LOOP_DEPTH) && loop_push && !loop_pop && clk_en |=> depth_r == 3'(MAX_LOOP_DEPTH))
    else $error("loop depth overflowed");
  a_depth_floor: assert property (@(posedge clk) disable iff (!rstn)
    depth_r == 3'h0 && loop_pop && !loop_push && clk_en |=> depth_r == 3'h0)
    else $error("loop depth underflowed");
  a_depth_read: assert property (@(posedge clk) disable iff (!rstn)
    reg_rd && clk_en && reg_addr == CORE_CONTROL_ADDR |=> reg_rdata[10:8] == $past(depth_r))
    else $error("loop depth read wrong");
  // a one asks for exit only while a loop runs; with no loop there is nothing to end
  a_exit_set: assert property (@(posedge clk) disable iff (!rstn)
    wr_ctrl && clk_en && reg_wdata[LOOP_EARLY_EXIT_BIT] && depth_r != 3'h0 |=> loop_exit_req)
    else $error("early exit request not raised");
  a_exit_clear: assert property (@(posedge clk) disable iff (!rstn)
    loop_pop && clk_en && !wr_ctrl |=> !loop_exit_req)
    else $error("early exit request outlived its loop");
  a_freeze: assert property (@(posedge clk) disable iff (!rstn)
    !clk_en |=> $stable(ctrl_r) && $stable(depth_r) && $stable(prod_ext) && $stable(reg_rdata)
      && $stable(loop_exit_req))
    else $error("state moved while clock enable low");

  // reset: this one runs without the disable so that it sees the reset edge
  a_reset_state: assert property (@(posedge clk)
    !rstn |=> ctrl_r == CORE_CONTROL_RESET && depth_r == 3'h0 && !prod_valid && reg_rdata == 16'h0000)
    else $error("state not cleared by reset");

endmodule // dmc_core

// file: include/dmc_pkg.sv
package dmc_pkg;
  // register map (word addresses on the plain register port)
  localparam logic [3:0] CORE_CONTROL_ADDR = 4'h0;
  localparam logic [3:0] MULT_OPA_ADDR     = 4'h1;
  localparam logic [3:0] MULT_OPB_ADDR     = 4'h2;
  localparam logic [3:0] MULT_CMD_ADDR     = 4'h3;
  localparam logic [3:0] PROD_LO_ADDR      = 4'h4;
  localparam logic [3:0] PROD_HI_ADDR      = 4'h5;
  localparam logic [3:0] PROD_EXT_ADDR     = 4'h6;
  localparam logic [3:0] PRIO_LOW_ADDR     = 4'h7;

  // core control field positions
  localparam int UNSIGNED_MULT_SEL_BIT  = 12;
  localparam int LOOP_EARLY_EXIT_BIT    = 11;
  localparam int LOOP_NEST_DEPTH_LSB    = 8;
  localparam int ACC_A_CLAMP_EN_BIT     = 7;
  localparam int ACC_B_CLAMP_EN_BIT     = 6;
  localparam int DATA_WRITE_CLAMP_EN_BIT = 5;
  localparam int CLAMP_WIDTH_SEL_BIT    = 4;
  localparam int PRIO_LEVEL_MSB_BIT     = 3;
  localparam int PROG_WINDOW_EN_BIT     = 2;

  // writable bits of core control and its reset value
  localparam logic [15:0] CORE_CONTROL_WMASK = 16'h10F4;
  localparam logic [15:0] CORE_CONTROL_RESET = 16'h0020;

  // multiply command field positions
  localparam int CMD_FRAC_BIT   = 0;
  localparam int CMD_BYTE_BIT   = 1;
  localparam int CMD_A_SIGN_BIT = 2;
  localparam int CMD_B_SIGN_BIT = 3;
  localparam int CMD_DSP_BIT    = 4;

  localparam int MAX_LOOP_DEPTH = 7;
  localparam logic [3:0] PRIO_MSB_THRESHOLD = 4'h7;
endpackage

// file: testbench/dmc_core_bench.sv
`timescale 1ns/1ns
module dmc_core_bench;
  import dmc_pkg::*;
  typedef struct {logic [4:0] cmd; logic [15:0] a; logic [15:0] b; logic [39:0] prod;} dmc_row_t;
  logic        clk, rstn, clk_en, reg_wr, reg_rd, loop_push, loop_pop;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic        loop_exit_req, acc_a_clamp_en, acc_b_clamp_en, data_write_clamp_en, clamp_width_sel, prog_window_en;
  logic [3:0]  prio_level;
  logic        prod_valid;
  logic [39:0] prod_ext;
  int          fail_count, total_checks;
  // mixed signedness, byte and dsp rows; expected products worked by hand
  dmc_row_t rows [8] = '{
    '{5'h0C, 16'h8000, 16'h7FFF, 40'hFF_C000_8000}, '{5'h00, 16'hFFFF, 16'hFFFF, 40'h00_FFFE_0001},
    '{5'h04, 16'hFFFF, 16'h0002, 40'hFF_FFFF_FFFE}, '{5'h0E, 16'h1280, 16'h0003, 40'h00_0000_FE80},
    '{5'h02, 16'h00FF, 16'h00FF, 40'h00_0000_FE01}, '{5'h11, 16'h4000, 16'h4000, 40'h00_2000_0000},
    '{5'h10, 16'hFFFE, 16'h0003, 40'hFF_FFFF_FFFA}, '{5'h11, 16'hC000, 16'h4000, 40'hFF_E000_0000}};

  dmc_core DUT (.clk(clk), .rstn(rstn), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .loop_push(loop_push), .loop_pop(loop_pop),
    .loop_exit_req(loop_exit_req), .acc_a_clamp_en(acc_a_clamp_en), .acc_b_clamp_en(acc_b_clamp_en),
    .data_write_clamp_en(data_write_clamp_en), .clamp_width_sel(clamp_width_sel),
    .prog_window_en(prog_window_en), .prio_level(prio_level), .prod_valid(prod_valid), .prod_ext(prod_ext));

  always #2 clk = ~clk;

  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // strobes are left up; the next operation or idle() lowers them, so no signal gets two writes per step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic idle();
    reg_wr <= 1'b0; reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    reg_addr <= a; reg_rd <= 1'b1; reg_wr <= 1'b0;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk({24'h0, reg_rdata}, {24'h0, exp});
  endtask
  // operands then command back to back; answer waited for under a bound
  task automatic mult(input dmc_row_t r);
    int n;
    wr(MULT_OPA_ADDR, r.a); wr(MULT_OPB_ADDR, r.b); wr(MULT_CMD_ADDR, {11'h0, r.cmd}); idle();
    n = 0;
    while (prod_valid !== 1'b1 && n < 6) begin
      @(posedge clk);
      n++;
    end
    chk({39'h0, prod_valid}, 40'h1);
    chk(prod_ext, r.prod);
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // watchdog sized well above the hundred or so cycles the sequence needs
  initial begin
    #(20000 * 4);
    fail_count++;
    final_report();
  end

  initial begin
    clk = 1'b0; rstn = 1'b0; clk_en = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; loop_push = 1'b0; loop_pop = 1'b0;
    reg_addr = 4'h0; reg_wdata = 16'h0000; fail_count = 0; total_checks = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) mult(rows[i]);
    rd(CORE_CONTROL_ADDR, 16'h0020);
    chk({35'h0, data_write_clamp_en, prio_level}, {35'h0, 1'b1, 4'h0});
    // all ones except the priority bit: unimplemented, depth and exit bits must not stick
    wr(CORE_CONTROL_ADDR, 16'hFFF7); idle();
    chk({35'h0, acc_a_clamp_en, acc_b_clamp_en, data_write_clamp_en, clamp_width_sel, prog_window_en}, 40'h1F);
    chk({39'h0, loop_exit_req}, 40'h0);
    rd(CORE_CONTROL_ADDR, 16'h10F4);
    wr(CORE_CONTROL_ADDR, 16'h0000); idle();
    chk({35'h0, acc_a_clamp_en, acc_b_clamp_en, data_write_clamp_en, clamp_width_sel, prog_window_en}, 40'h0);
    // unsigned dsp select zero-extends the same operands that gave -6 above
    wr(CORE_CONTROL_ADDR, 16'h1000); idle();
    mult('{5'h10, 16'hFFFE, 16'h0003, 40'h00_0002_FFFA});
    rd(PROD_LO_ADDR, 16'hFFFA);
    rd(PROD_HI_ADDR, 16'h0002);
    rd(PROD_EXT_ADDR, 16'h0000);
    // eight pushes saturate the nesting count at seven
    loop_push <= 1'b1;
    repeat (8) @(posedge clk);
    loop_push <= 1'b0;
    rd(CORE_CONTROL_ADDR, 16'h1700);
    wr(CORE_CONTROL_ADDR, 16'h1800); idle();
    chk({39'h0, loop_exit_req}, 40'h1);
    rd(CORE_CONTROL_ADDR, 16'h1700);
    loop_pop <= 1'b1;
    @(posedge clk);
    loop_pop <= 1'b0;
    @(posedge clk);
    chk({39'h0, loop_exit_req}, 40'h0);
    // a write while the clock enable is low must be lost
    clk_en <= 1'b0;
    wr(CORE_CONTROL_ADDR, 16'h0000); idle();
    clk_en <= 1'b1;
    rd(CORE_CONTROL_ADDR, 16'h1600);
    wr(PRIO_LOW_ADDR, 16'h0005); idle();
    chk({36'h0, prio_level}, 40'h5);
    // mid-run reset with loops nested and a product held: all returns to reset values
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk({35'h0, data_write_clamp_en, prio_level}, {35'h0, 1'b1, 4'h0});
    chk({39'h0, loop_exit_req}, 40'h0);
    chk(prod_ext, 40'h0);
    rd(CORE_CONTROL_ADDR, 16'h0020);
    for (int a = 8; a < 16; a++) rd(a[3:0], 16'h0000);
    final_report();
  end
endmodule // dmc_core_bench
